// ==== rtl/option_and_interrupt_control.sv ====
// Summary of operation
// [R1] Pull-up disable bit set turns all port-B pull-ups off, else per pin.
// [R2] Edge select bit picks rising (1) or falling (0) external pin edge.
// [R3] Clock source bit picks external counter pin (1) or instruction clock.
// [R4] Source edge bit: 1 counts high-to-low, 0 counts low-to-high.
// [R5] Assign bit 1 gives prescaler to watchdog, counter runs 1:1.
// [R6] Rate codes give counter 1:2..1:256, watchdog 1:1..1:128.
// [R7] Flags set on their events regardless of any enable bit.
// [R8] Global enable passes unmasked sources; cleared it blocks all.
// [R9] Write-complete enable gates the nonvolatile write-done interrupt.
// [R10] Overflow enable gates the counter overflow interrupt.
// [R11] Bits 4,3 enable pin and change; bits 2..0 flags, software clears.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module option_and_interrupt_control #(
  parameter int unsigned PORT_W = option_irq_pkg::PORT_B_W,
  parameter int unsigned INSTR_DIV = option_irq_pkg::INSTR_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [option_irq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [option_irq_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [option_irq_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic [PORT_W-1:0] portBPullupGate,
  output logic [PORT_W-1:0] portBPullupOn,
  input wire logic extIrqPin,
  input wire logic extCounterClkPin,
  input wire logic watchdogTick,
  input wire logic counterOverflow,
  input wire logic portChange,
  input wire logic nvWriteDoneFlag,
  output logic instrCycleTick,
  output logic counterInc,
  output logic watchdogInc,
  output logic irqRequest
);

  localparam int unsigned RW = option_irq_pkg::REG_W;
  localparam int unsigned DW = option_irq_pkg::DATA_W;
  localparam int unsigned DIVW = option_irq_pkg::INSTR_DIV_W;
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(INSTR_DIV - 1);

  typedef struct packed {
    logic [RW-1:0] optionConfig;
    logic [RW-1:0] interruptControl;
    logic extPinPrev;
    logic cntPinPrev;
    logic assignPrev;
    logic [DIVW-1:0] divCnt;
    logic ack;
    logic [DW-1:0] rdata;
    logic [PORT_W-1:0] pullupOn;
  } ctrl_state_t;

  localparam ctrl_state_t RESET_STATE = '{
    optionConfig: option_irq_pkg::OPTION_CONFIG_RST,
    interruptControl: option_irq_pkg::INTERRUPT_CONTROL_RST,
    extPinPrev: 1'b0,
    cntPinPrev: 1'b0,
    assignPrev: option_irq_pkg::OPTION_CONFIG_RST[
      option_irq_pkg::PRESCALER_ASSIGN_BIT],
    divCnt: '0,
    ack: 1'b0,
    rdata: '0,
    pullupOn: '0
  };

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic [option_irq_pkg::IDX_W-1:0] wordIdx;
  logic hitOption;
  logic hitIntcon;
  logic request;
  logic writeTaken;
  logic pullupDisable;
  logic extIrqEdgeSel;
  logic counterClkSrcSel;
  logic counterSrcEdgeSel;
  logic prescalerAssign;
  logic [option_irq_pkg::PRESCALE_RATE_W-1:0] prescaleRate;
  logic extRise;
  logic extFall;
  logic extIrqEvent;
  logic cntPinEvent;
  logic counterSrcTick;
  logic presTick;
  logic presPulse;
  logic [RW-1:0] ic;
  logic [PORT_W-1:0] pullupNext;

  // ==========================================================
  // Field views
  assign pullupDisable = s_q.optionConfig[option_irq_pkg::PULLUP_DISABLE_BIT];
  assign extIrqEdgeSel =
    s_q.optionConfig[option_irq_pkg::EXT_IRQ_EDGE_SEL_BIT];
  assign counterClkSrcSel =
    s_q.optionConfig[option_irq_pkg::COUNTER_CLK_SRC_SEL_BIT];
  assign counterSrcEdgeSel =
    s_q.optionConfig[option_irq_pkg::COUNTER_SRC_EDGE_SEL_BIT];
  assign prescalerAssign =
    s_q.optionConfig[option_irq_pkg::PRESCALER_ASSIGN_BIT];
  assign prescaleRate = s_q.optionConfig[option_irq_pkg::PRESCALE_RATE_LSB +:
    option_irq_pkg::PRESCALE_RATE_W];
  assign ic = s_q.interruptControl;

  // ==========================================================
  // Bus decode
  assign wordIdx = address[option_irq_pkg::ADDR_W-1:2];
  assign hitOption = (wordIdx == option_irq_pkg::IDX_OPTION_CONFIG);
  assign hitIntcon = (wordIdx == option_irq_pkg::IDX_INTERRUPT_CONTROL);
  assign request = read | write;
  // One wait state keeps read data registered
  assign waitrequest = request & ~s_q.ack;
  assign writeTaken = write & s_q.ack & byteenable[0];
  assign readdata = s_q.rdata;

  // ==========================================================
  // Pin edges and clock selection
  assign extRise = extIrqPin & ~s_q.extPinPrev;
  assign extFall = ~extIrqPin & s_q.extPinPrev;
  assign extIrqEvent = extIrqEdgeSel ? extRise : extFall; // [R2]
  assign cntPinEvent = counterSrcEdgeSel ?
    (~extCounterClkPin & s_q.cntPinPrev) :
    (extCounterClkPin & ~s_q.cntPinPrev); // [R4]
  assign instrCycleTick = (s_q.divCnt == DIV_LAST);
  assign counterSrcTick = counterClkSrcSel ? cntPinEvent :
    instrCycleTick; // [R3]

  // ==========================================================
  // Prescaler routing
  assign presTick = prescalerAssign ? watchdogTick : counterSrcTick; // [R5]
  assign counterInc = prescalerAssign ? counterSrcTick : presPulse; // [R5]
  assign watchdogInc = prescalerAssign ? presPulse : watchdogTick; // [R5]

  prescaler #(
    .CNT_W(option_irq_pkg::PRESCALE_CNT_W),
    .RATE_W(option_irq_pkg::PRESCALE_RATE_W),
    .EXP_W(option_irq_pkg::PRESCALE_EXP_W)
  ) u_prescaler (
    .clk(clk),
    .rst(rst),
    .clear(prescalerAssign != s_q.assignPrev),
    .tick(presTick),
    .rate(prescaleRate),
    .forCounter(~prescalerAssign),
    .pulse(presPulse)
  );

  // ==========================================================
  // Interrupt request
  assign irqRequest = ic[option_irq_pkg::GLOBAL_IRQ_EN_BIT] & ( // [R8]
    (ic[option_irq_pkg::NV_WRITE_DONE_IRQ_EN_BIT] & nvWriteDoneFlag) | // [R9]
    (ic[option_irq_pkg::COUNTER_OVF_IRQ_EN_BIT] &
     ic[option_irq_pkg::COUNTER_OVF_FLAG_BIT]) | // [R10]
    (ic[option_irq_pkg::EXT_PIN_IRQ_EN_BIT] &
     ic[option_irq_pkg::EXT_PIN_IRQ_FLAG_BIT]) | // [R11]
    (ic[option_irq_pkg::PORT_CHANGE_IRQ_EN_BIT] &
     ic[option_irq_pkg::PORT_CHANGE_FLAG_BIT])); // [R11]

  assign portBPullupOn = s_q.pullupOn;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.extPinPrev = extIrqPin;
    s_d.cntPinPrev = extCounterClkPin;
    s_d.assignPrev = prescalerAssign;
    s_d.divCnt = instrCycleTick ? '0 : s_q.divCnt + DIVW'(1);
    s_d.ack = request & ~s_q.ack;
    s_d.pullupOn = pullupNext;
    if (request & ~s_q.ack) begin
      s_d.rdata = '0;
      if (hitOption) begin
        s_d.rdata = DW'(s_q.optionConfig);
      end else if (hitIntcon) begin
        s_d.rdata = DW'(s_q.interruptControl);
      end
    end
    if (writeTaken && hitOption) begin
      s_d.optionConfig = writedata[RW-1:0];
    end
    if (writeTaken && hitIntcon) begin
      s_d.interruptControl = writedata[RW-1:0]; // [R11]
    end
    // Set after the write so an event in the clearing cycle survives
    if (counterOverflow) begin
      s_d.interruptControl[option_irq_pkg::COUNTER_OVF_FLAG_BIT] = 1'b1; // [R7]
    end
    if (extIrqEvent) begin
      s_d.interruptControl[option_irq_pkg::EXT_PIN_IRQ_FLAG_BIT] = 1'b1; // [R7]
    end
    if (portChange) begin
      s_d.interruptControl[option_irq_pkg::PORT_CHANGE_FLAG_BIT] = 1'b1; // [R7]
    end
  end

  // ==========================================================
  // Per-pin pull-up gating
  for (genvar i = 0; i < PORT_W; i++) begin : g_pullup
    assign pullupNext[i] = ~pullupDisable & portBPullupGate[i]; // [R1]
  end

  // ==========================================================
  // State register
  // One process owns the whole struct, pull-up bits included
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : option_and_interrupt_control

`default_nettype wire

// ==== pkg/option_irq_pkg.sv ====
package option_irq_pkg;

  // ==========================================================
  // Register map (printed offsets are indices; byte = 4 x index)
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [IDX_W-1:0] IDX_OPTION_CONFIG = 8'h81;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] OPTION_CONFIG_RST = 8'hFF;
  localparam logic [REG_W-1:0] INTERRUPT_CONTROL_RST = 8'h00;

  // ==========================================================
  // Option config fields
  localparam int unsigned PULLUP_DISABLE_BIT = 7;
  localparam int unsigned EXT_IRQ_EDGE_SEL_BIT = 6;
  localparam int unsigned COUNTER_CLK_SRC_SEL_BIT = 5;
  localparam int unsigned COUNTER_SRC_EDGE_SEL_BIT = 4;
  localparam int unsigned PRESCALER_ASSIGN_BIT = 3;
  localparam int unsigned PRESCALE_RATE_LSB = 0;
  localparam int unsigned PRESCALE_RATE_W = 3;

  // ==========================================================
  // Interrupt control fields
  localparam int unsigned GLOBAL_IRQ_EN_BIT = 7;
  localparam int unsigned NV_WRITE_DONE_IRQ_EN_BIT = 6;
  localparam int unsigned COUNTER_OVF_IRQ_EN_BIT = 5;
  localparam int unsigned EXT_PIN_IRQ_EN_BIT = 4;
  localparam int unsigned PORT_CHANGE_IRQ_EN_BIT = 3;
  localparam int unsigned COUNTER_OVF_FLAG_BIT = 2;
  localparam int unsigned EXT_PIN_IRQ_FLAG_BIT = 1;
  localparam int unsigned PORT_CHANGE_FLAG_BIT = 0;

  // ==========================================================
  // Timing and widths
  localparam int unsigned INSTR_DIV = 4;
  localparam int unsigned INSTR_DIV_W = 2;
  localparam int unsigned PRESCALE_CNT_W = 8;
  localparam int unsigned PRESCALE_EXP_W = 4;
  localparam int unsigned PORT_B_W = 8;

endpackage : option_irq_pkg

// ==== rtl/prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none

module prescaler #(
  parameter int unsigned CNT_W = option_irq_pkg::PRESCALE_CNT_W,
  parameter int unsigned RATE_W = option_irq_pkg::PRESCALE_RATE_W,
  parameter int unsigned EXP_W = option_irq_pkg::PRESCALE_EXP_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic [RATE_W-1:0] rate,
  input wire logic forCounter,
  output logic pulse
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } pres_state_t;

  pres_state_t s_q;
  pres_state_t s_d;
  logic [EXP_W-1:0] divExp;
  logic [CNT_W:0] maskWide;
  logic [CNT_W-1:0] mask;

  // ==========================================================
  // Ratio select
  always_comb begin
    divExp = EXP_W'(rate) + EXP_W'(forCounter); // [R6]
    maskWide = ((CNT_W+1)'(1) << divExp) - (CNT_W+1)'(1);
    mask = maskWide[CNT_W-1:0];
    pulse = tick && ((s_q.cnt & mask) == mask); // [R6]
    s_d = s_q;
    if (clear) begin
      s_d.cnt = '0;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : prescaler

`default_nettype wire

// ==== tb/option_irq_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module option_irq_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic [7:0] portBPullupGate,
  input wire logic [7:0] portBPullupOn,
  input wire logic extIrqPin,
  input wire logic extCounterClkPin,
  input wire logic counterOverflow,
  input wire logic portChange,
  input wire logic nvWriteDoneFlag,
  input wire logic instrCycleTick,
  input wire logic counterInc,
  input wire logic irqRequest
);
  // ==========================================
  // Shadow registers, fed only by bus writes
  logic [7:0] opt_q;
  logic [7:0] ctl_q;
  logic take;
  assign take = write && !waitrequest && byteenable[0];
  always_ff @(posedge clk) begin
    if (rst) begin
      opt_q <= option_irq_pkg::OPTION_CONFIG_RST;
      ctl_q <= option_irq_pkg::INTERRUPT_CONTROL_RST;
    end else if (take && address[9:2] == option_irq_pkg::IDX_OPTION_CONFIG) begin
      opt_q <= writedata[7:0];
    end else if (take &&
        address[9:2] == option_irq_pkg::IDX_INTERRUPT_CONTROL) begin
      ctl_q <= writedata[7:0];
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pullup_gated: assert property (
    !$past(rst) |-> portBPullupOn ==
      ($past(opt_q[7]) ? 8'h00 : $past(portBPullupGate)))
    else $error("pull-up output wrong");
  a_global_block: assert property (!ctl_q[7] |-> !irqRequest)
    else $error("request with global enable off");
  a_nv_enable: assert property (
    ctl_q[7] && ctl_q[6] && nvWriteDoneFlag |-> irqRequest)
    else $error("write-done request missing");
  a_ovf_irq: assert property (
    counterOverflow |=> !(ctl_q[7] && ctl_q[5]) || irqRequest)
    else $error("overflow request missing");
  a_pin_edge: assert property (
    (opt_q[6] ? $rose(extIrqPin) : $fell(extIrqPin))
      |=> !(ctl_q[7] && ctl_q[4]) || irqRequest)
    else $error("pin request missing");
  a_change_irq: assert property (
    portChange |=> !(ctl_q[7] && ctl_q[3]) || irqRequest)
    else $error("change request missing");
  a_counter_internal: assert property (
    !opt_q[5] && opt_q[3] |-> counterInc == instrCycleTick)
    else $error("undivided count wrong");
  a_counter_ext: assert property (
    !$past(rst) && opt_q[5] && opt_q[3] && (opt_q[4] ?
      $fell(extCounterClkPin) : $rose(extCounterClkPin))
      |-> ##[0:3] counterInc)
    else $error("external edge not counted");
endmodule : option_irq_properties
bind option_and_interrupt_control option_irq_properties props (
  .clk(clk), .rst(rst), .address(address), .write(write),
  .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest), .portBPullupGate(portBPullupGate),
  .portBPullupOn(portBPullupOn), .extIrqPin(extIrqPin),
  .extCounterClkPin(extCounterClkPin), .counterOverflow(counterOverflow),
  .portChange(portChange), .nvWriteDoneFlag(nvWriteDoneFlag),
  .instrCycleTick(instrCycleTick), .counterInc(counterInc),
  .irqRequest(irqRequest)
);
`default_nettype wire

// ==== tb/option_and_interrupt_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module option_and_interrupt_control_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest, tick, cInc, wInc, irq;
  logic [7:0] gate = 8'h00;
  logic [7:0] pullOn;
  logic pin = 1'b0, cPin = 1'b0, wdTick = 1'b0;
  logic ovf = 1'b0, chg = 1'b0, nvDone = 1'b0;
  int failures = 0, checksDone = 0, seed = 56, c, w;
  logic [7:0] d;
  localparam logic [9:0] OPT = {option_irq_pkg::IDX_OPTION_CONFIG, 2'b00};
  localparam logic [9:0] CTL = {option_irq_pkg::IDX_INTERRUPT_CONTROL, 2'b00};
  always #20 clk = ~clk;
  option_and_interrupt_control dut (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .portBPullupGate(gate), .portBPullupOn(pullOn), .extIrqPin(pin),
    .extCounterClkPin(cPin), .watchdogTick(wdTick), .counterOverflow(ovf),
    .portChange(chg), .nvWriteDoneFlag(nvDone), .instrCycleTick(tick),
    .counterInc(cInc), .watchdogInc(wInc), .irqRequest(irq));
  // ==========================================
  // Checking and bus tasks
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] v,
                     output logic [31:0] q);
    int i;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h000000, v};
    // Request holds until the edge that sees waitrequest low
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      failures++;
      complete_run();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask : wr
  task automatic rdc(input string what, input logic [9:0] a,
                     input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(what, q, {24'h000000, exp});
  endtask : rdc
  task automatic irqc(input logic e);
    @(negedge clk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask : irqc
  // Counts pulses; a short tail lets late external edges land
  task automatic run(input int n, input bit wd, input bit ex);
    c = 0;
    w = 0;
    for (int i = 0; i < n + 8 * ex; i++) begin
      @(posedge clk);
      wdTick <= wd && i < n && !wdTick;
      cPin <= (ex && i < n) ? !cPin : cPin;
      @(negedge clk);
      c += int'(cInc === 1'b1);
      w += int'(wInc === 1'b1);
    end
  endtask : run
  // ==========================================
  // Scenarios
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc("option", OPT, option_irq_pkg::OPTION_CONFIG_RST);
    rdc("intctl", CTL, option_irq_pkg::INTERRUPT_CONTROL_RST);
    rdc("unmapped", 10'h3FC, 8'h00);
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed));
      wr(OPT, d);
      rdc("option rw", OPT, d);
      d = 8'($random(seed));
      wr(CTL, d);
      rdc("intctl rw", CTL, d);
    end
    wr(OPT, 8'h08);
    gate <= 8'($random(seed));
    repeat (2) @(negedge clk);
    check("pullup on", {24'h0, pullOn}, {24'h0, gate});
    wr(OPT, 8'h88);
    repeat (2) @(negedge clk);
    check("pullup off", {24'h0, pullOn}, 32'h0);
    $display("test registers done");
    wr(CTL, 8'h00);
    wr(OPT, 8'h48);
    @(posedge clk);
    ovf <= 1'b1;
    chg <= 1'b1;
    pin <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    chg <= 1'b0;
    rdc("flags", CTL, 8'h07);
    irqc(1'b0);
    wr(CTL, 8'hBF);
    irqc(1'b1);
    wr(CTL, 8'hB8);
    irqc(1'b0);
    wr(OPT, 8'h08);
    pin <= 1'b0;
    repeat (2) @(posedge clk);
    rdc("fall flag", CTL, 8'hBA);
    irqc(1'b1);
    wr(CTL, 8'h40);
    nvDone <= 1'b1;
    irqc(1'b0);
    wr(CTL, 8'hC0);
    irqc(1'b1);
    wr(CTL, 8'h80);
    irqc(1'b0);
    nvDone <= 1'b0;
    $display("test interrupts done");
    // Windows hold whole periods, so counts are phase free
    for (int r = 0; r < 8; r++) begin
      wr(OPT, 8'h80 | 8'(r));
      run(1024, 1'b0, 1'b0);
      check("counter rate", c, 256 >> (r + 1));
      wr(OPT, 8'h88 | 8'(r));
      run(512, 1'b1, 1'b0);
      check("watchdog rate", w, 256 >> r);
      check("counter undivided", c, 128);
    end
    wr(OPT, 8'hA8);
    run(40, 1'b0, 1'b1);
    check("ext rising", c, 20);
    wr(OPT, 8'hB8);
    run(40, 1'b0, 1'b1);
    check("ext falling", c, 20);
    $display("test prescaler done");
    complete_run();
  end
endmodule : option_and_interrupt_control_test
`default_nettype wire
